// ==== core/fis_pkg.sv ====
// package of the front-end instruction sequencer: register map, field layout, codes, counts
// assumes a 20 MHz system clock and a 32-bit axi4-lite register bus
package fis_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int FIS_SEQ_DEPTH = 4096;
    localparam int FIS_SEQ_AW = 12;
    localparam int FIS_WORD_W = 22;
    localparam int FIS_ROL_DEPTH = 2048;
    localparam int FIS_ROL_W = 12;
    localparam int FIS_HIT_DEPTH = 64;

    // ------------------------------------------------------------
    // register map, byte addresses = index * 4
    // ------------------------------------------------------------
    localparam logic [15:0] FIS_IDX_SEQ_MEM = 16'h0000;
    localparam logic [15:0] FIS_IDX_ROL_A = 16'h1000;
    localparam logic [15:0] FIS_IDX_ROL_B = 16'h1800;
    localparam logic [15:0] FIS_IDX_ROL_END = 16'h1fff;
    localparam logic [15:0] FIS_IDX_HIT_A = 16'h5000;
    localparam logic [15:0] FIS_IDX_HIT_END = 16'h507f;
    localparam logic [15:0] FIS_IDX_SCAN_DLY = 16'h510a;
    localparam logic [15:0] FIS_IDX_CTRL = 16'h5110;
    localparam logic [15:0] FIS_IDX_STATUS = 16'h5111;
    localparam logic [15:0] FIS_IDX_SCLK_SEL = 16'h800c;

    localparam logic [12:0] FIS_SCAN_DLY_RST = 13'h0e10;
    localparam logic [1:0] FIS_SCLK_SEL_RST = 2'h0;
    localparam logic [1:0] FIS_RESP_OKAY = 2'h0;
    localparam logic [1:0] FIS_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // instruction word fields
    // ------------------------------------------------------------
    localparam int FIS_TYPE_HI = 21;
    localparam int FIS_TYPE_LO = 20;
    localparam int FIS_OP_HI = 19;
    localparam int FIS_OP_LO = 16;
    localparam int FIS_LOOP_CNT_HI = 15;
    localparam int FIS_LOOP_CNT_LO = 12;

    localparam logic [1:0] FIS_TYPE_READ = 2'h0;
    localparam logic [1:0] FIS_TYPE_CMD = 2'h1;
    localparam logic [1:0] FIS_TYPE_WRITE = 2'h2;
    localparam logic [1:0] FIS_TYPE_INT = 2'h3;

    localparam logic [3:0] FIS_OP_LOOP = 4'h1;
    localparam logic [3:0] FIS_OP_WAIT = 4'h2;
    localparam logic [3:0] FIS_OP_SEQ_END = 4'h8;
    localparam logic [3:0] FIS_OP_MEM_END = 4'hf;

    // slow clock: 20 MHz divided by 4 << sel
    localparam logic [7:0] FIS_SCLK_HALF_BASE = 8'h02;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] kind;
        logic [19:0] word;
        logic [19:0] data;
    } fis_card_req_t;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } fis_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fis_axi_rsp_t;

    typedef enum {FIS_IDLE, FIS_FETCH, FIS_DECODE, FIS_DATA, FIS_ISSUE, FIS_WAIT} fis_state_t;

endpackage : fis_pkg

// ==== core/fis_slow_clock.sv ====
// slow control clock generator for the front-end cards
// assumes one system clock; the output is a registered level toggled on a divider enable
`timescale 1ns/100ps
module fis_slow_clock (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // frequency select
    input wire logic [1:0] freq_sel,
    // slow clock out
    output logic slow_clk
);
    import fis_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic clk;
    } fis_sclk_state_t;

    fis_sclk_state_t st_ff;
    fis_sclk_state_t nxt_st;
    logic [7:0] half;

    always_comb begin
        half = FIS_SCLK_HALF_BASE << freq_sel;
        nxt_st = st_ff;
        if (st_ff.cnt + 8'h01 >= half) begin
            nxt_st.cnt = 8'h00;
            nxt_st.clk = ~st_ff.clk;
        end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign slow_clk = st_ff.clk;

endmodule : fis_slow_clock

// ==== core/fis_sequencer.sv ====
// front-end instruction sequencer with its register and memory map on axi4-lite
// assumes a single 20 MHz clock; the card bus engine outside answers each request with a done pulse
//
// Operation
// [RL1] The sequence memory holds 4096 words of 22 bits that software loads before a run.
// [RL2] Only card operations and the sequencer's own internal operations are executed.
// [RL3] Bits 21:20 pick read, command, write or internal, and a write takes an address word then a data word.
// [RL4] An internal word carries a 4-bit operation code above a 16-bit parameter.
// [RL5] Exactly four internal operations are recognised to steer the surrounding card operations.
// [RL6] Operation 0x1 repeats a block of instructions a programmed number of times.
// [RL7] Operation 0x2 stalls the sequencer for the number of clock cycles in its parameter; the code stays in FIS_WAIT for the parameter plus one cycles.
// [RL8] Operation 0x8 ends a sequence and ignores its parameter.
// [RL9] Operation 0xf ends the memory contents and ignores its parameter.
// [RL10] Software loads a sequence, starts it with one command, and the sequencer runs it alone to the end.
// [RL11] Readout list storage is two 12-bit by 2048 memories, branch a at 0x1000 and branch b at 0x1800.
// [RL12] Hit list storage is two 32-bit by 64 memories, branch a in the lower half of 0x5000 to 0x507f.
// [RL13] The scan event length time comes from a 13-bit register at 0x510a that resets to 0xe10.
// [RL14] A slow control clock goes to the cards with its rate picked by a 2-bit register at 0x800c.
// [RL15] A loop parameter holds the count in bits 15:12 and the return address in bits 11:0.
// [RL16] An end operation stops fetching, returns to idle and shows completion to software.
`timescale 1ns/100ps
module fis_sequencer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register bus
    input wire fis_pkg::fis_axi_req_t axi_req,
    output fis_pkg::fis_axi_rsp_t axi_rsp,
    // card bus engine
    output logic card_req_valid,
    output fis_pkg::fis_card_req_t card_req,
    input wire logic card_done,
    // configuration to the card side
    output logic [12:0] scan_length_delay,
    output logic slow_clk
);
    import fis_pkg::*;

    // ------------------------------------------------------------
    // storage, one flat array per memory, addressed by index
    // ------------------------------------------------------------
    logic [FIS_WORD_W-1:0] seq_mem [FIS_SEQ_DEPTH];
    logic [FIS_ROL_W-1:0] rol_mem [2*FIS_ROL_DEPTH];
    logic [31:0] hit_mem [2*FIS_HIT_DEPTH];

    typedef struct packed {
        fis_state_t st;
        logic [FIS_SEQ_AW-1:0] pc;
        logic [FIS_WORD_W-1:0] ir;
        logic [19:0] addr_word;
        logic [15:0] wait_cnt;
        logic [3:0] loop_left;
        logic loop_active;
        logic done;
        logic mem_end;
        logic aw_got;
        logic w_got;
        logic [15:0] aw_idx;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [12:0] scan_dly;
        logic [1:0] sclk_sel;
        logic req_valid;
        fis_card_req_t req;
    } fis_seq_state_t;

    fis_seq_state_t s_ff;
    fis_seq_state_t nxt_s;

    logic wr_fire;
    logic rd_fire;
    logic [15:0] ar_idx;
    logic start_cmd;
    logic [FIS_WORD_W-1:0] fetched;

    assign ar_idx = axi_req.araddr[17:2];
    // write happens once address and data are both held
    assign wr_fire = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
    assign rd_fire = axi_req.arvalid && !s_ff.rvalid;
    assign fetched = seq_mem[s_ff.pc];
    assign start_cmd = wr_fire && s_ff.aw_idx == FIS_IDX_CTRL && s_ff.wdata[0]
        && s_ff.st == FIS_IDLE;

    // ------------------------------------------------------------
    // memory writes from the bus
    // ------------------------------------------------------------
    // writes into the sequence memory are let through while running; software owns the ordering
    always_ff @(posedge clk_sys) begin
        if (wr_fire) begin
            if (s_ff.aw_idx < 16'(FIS_SEQ_DEPTH)) begin
                seq_mem[s_ff.aw_idx[11:0]] <= s_ff.wdata[FIS_WORD_W-1:0]; // see [RL1]
            end
            if (s_ff.aw_idx >= FIS_IDX_ROL_A && s_ff.aw_idx <= FIS_IDX_ROL_END) begin
                rol_mem[s_ff.aw_idx[11:0]] <= s_ff.wdata[FIS_ROL_W-1:0]; // see [RL11]
            end
            if (s_ff.aw_idx >= FIS_IDX_HIT_A && s_ff.aw_idx <= FIS_IDX_HIT_END) begin
                hit_mem[s_ff.aw_idx[6:0]] <= s_ff.wdata; // see [RL12]
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;

        // bus write channel: address and data in either order
        if (axi_req.awvalid && !s_ff.aw_got) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.aw_idx = axi_req.awaddr[17:2];
        end
        if (axi_req.wvalid && !s_ff.w_got) begin
            nxt_s.w_got = 1'b1;
            nxt_s.wdata = axi_req.wdata;
        end
        if (wr_fire) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = FIS_RESP_OKAY;
            case (s_ff.aw_idx)
                FIS_IDX_SCAN_DLY: nxt_s.scan_dly = s_ff.wdata[12:0]; // see [RL13]
                FIS_IDX_SCLK_SEL: nxt_s.sclk_sel = s_ff.wdata[1:0]; // see [RL14]
                FIS_IDX_CTRL: begin
                    // status clear; completion set below wins if it lands in the same cycle
                    if (s_ff.wdata[1]) begin
                        nxt_s.done = 1'b0;
                        nxt_s.mem_end = 1'b0;
                    end
                end
                default: begin
                    if (!(s_ff.aw_idx < 16'(FIS_SEQ_DEPTH)
                          || (s_ff.aw_idx >= FIS_IDX_ROL_A && s_ff.aw_idx <= FIS_IDX_ROL_END)
                          || (s_ff.aw_idx >= FIS_IDX_HIT_A && s_ff.aw_idx <= FIS_IDX_HIT_END))) begin
                        nxt_s.bresp = FIS_RESP_SLVERR;
                    end
                end
            endcase
        end
        if (s_ff.bvalid && axi_req.bready) begin
            nxt_s.bvalid = 1'b0;
        end

        // bus read channel
        if (rd_fire) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = FIS_RESP_OKAY;
            nxt_s.rdata = 32'h0000_0000;
            if (ar_idx < 16'(FIS_SEQ_DEPTH)) begin
                nxt_s.rdata = {10'h000, seq_mem[ar_idx[11:0]]};
            end else if (ar_idx >= FIS_IDX_ROL_A && ar_idx <= FIS_IDX_ROL_END) begin
                nxt_s.rdata = {20'h00000, rol_mem[ar_idx[11:0]]};
            end else if (ar_idx >= FIS_IDX_HIT_A && ar_idx <= FIS_IDX_HIT_END) begin
                nxt_s.rdata = hit_mem[ar_idx[6:0]];
            end else if (ar_idx == FIS_IDX_SCAN_DLY) begin
                nxt_s.rdata = {19'h00000, s_ff.scan_dly};
            end else if (ar_idx == FIS_IDX_SCLK_SEL) begin
                nxt_s.rdata = {30'h00000000, s_ff.sclk_sel};
            end else if (ar_idx == FIS_IDX_CTRL) begin
                nxt_s.rdata = 32'h0000_0000;
            end else if (ar_idx == FIS_IDX_STATUS) begin
                nxt_s.rdata = {4'h0, s_ff.pc, 13'h0000, s_ff.mem_end, s_ff.done,
                               1'(s_ff.st != FIS_IDLE)};
            end else begin
                nxt_s.rresp = FIS_RESP_SLVERR;
            end
        end
        if (s_ff.rvalid && axi_req.rready) begin
            nxt_s.rvalid = 1'b0;
        end

        // card request handshake
        if (s_ff.req_valid && card_done) begin
            nxt_s.req_valid = 1'b0;
        end

        // sequencer
        case (s_ff.st)
            FIS_IDLE: begin
                if (start_cmd) begin
                    nxt_s.st = FIS_FETCH; // see [RL10]
                    nxt_s.pc = '0;
                    nxt_s.loop_active = 1'b0;
                    nxt_s.done = 1'b0;
                    nxt_s.mem_end = 1'b0;
                end
            end
            FIS_FETCH: begin
                nxt_s.ir = fetched;
                nxt_s.pc = s_ff.pc + 12'h001;
                nxt_s.st = FIS_DECODE;
            end
            FIS_DECODE: begin
                case (s_ff.ir[FIS_TYPE_HI:FIS_TYPE_LO]) // see [RL3]
                    FIS_TYPE_READ, FIS_TYPE_CMD: begin
                        nxt_s.req.kind = s_ff.ir[FIS_TYPE_HI:FIS_TYPE_LO];
                        nxt_s.req.word = s_ff.ir[19:0];
                        nxt_s.req.data = '0;
                        nxt_s.req_valid = 1'b1;
                        nxt_s.st = FIS_ISSUE;
                    end
                    FIS_TYPE_WRITE: begin
                        nxt_s.addr_word = s_ff.ir[19:0];
                        nxt_s.st = FIS_DATA; // see [RL3]
                    end
                    default: begin
                        // internal op: 4-bit code over a 16-bit parameter
                        case (s_ff.ir[FIS_OP_HI:FIS_OP_LO]) // see [RL4] see [RL5]
                            FIS_OP_LOOP: begin
                                // count loaded on first arrival, return while repetitions remain
                                if (!s_ff.loop_active) begin
                                    nxt_s.loop_active = 1'b1;
                                    nxt_s.loop_left = s_ff.ir[FIS_LOOP_CNT_HI:FIS_LOOP_CNT_LO]; // see [RL15]
                                    if (s_ff.ir[FIS_LOOP_CNT_HI:FIS_LOOP_CNT_LO] != 4'h0) begin
                                        nxt_s.pc = s_ff.ir[FIS_SEQ_AW-1:0]; // see [RL6]
                                    end else begin
                                        nxt_s.loop_active = 1'b0;
                                    end
                                end else if (s_ff.loop_left > 4'h1) begin
                                    nxt_s.loop_left = s_ff.loop_left - 4'h1;
                                    nxt_s.pc = s_ff.ir[FIS_SEQ_AW-1:0]; // see [RL15]
                                end else begin
                                    nxt_s.loop_active = 1'b0;
                                end
                                nxt_s.st = FIS_FETCH;
                            end
                            FIS_OP_WAIT: begin
                                nxt_s.wait_cnt = s_ff.ir[15:0];
                                nxt_s.st = FIS_WAIT; // see [RL7]
                            end
                            FIS_OP_SEQ_END: begin
                                nxt_s.done = 1'b1; // see [RL8] see [RL16]
                                nxt_s.st = FIS_IDLE;
                            end
                            FIS_OP_MEM_END: begin
                                nxt_s.done = 1'b1; // see [RL9] see [RL16]
                                nxt_s.mem_end = 1'b1;
                                nxt_s.st = FIS_IDLE;
                            end
                            default: nxt_s.st = FIS_FETCH; // unknown codes skipped, see [RL2]
                        endcase
                    end
                endcase
            end
            FIS_DATA: begin
                // second word of a write is its data
                nxt_s.req.kind = FIS_TYPE_WRITE;
                nxt_s.req.word = s_ff.addr_word;
                nxt_s.req.data = fetched[19:0];
                nxt_s.req_valid = 1'b1;
                nxt_s.pc = s_ff.pc + 12'h001;
                nxt_s.st = FIS_ISSUE;
            end
            FIS_ISSUE: begin
                if (s_ff.req_valid && card_done) begin
                    nxt_s.st = FIS_FETCH;
                end
            end
            FIS_WAIT: begin
                if (s_ff.wait_cnt == 16'h0000) begin
                    nxt_s.st = FIS_FETCH;
                end else begin
                    nxt_s.wait_cnt = s_ff.wait_cnt - 16'h0001; // see [RL7]
                end
            end
            default: nxt_s.st = FIS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_ff <= '0;
            s_ff.st <= FIS_IDLE;
            s_ff.scan_dly <= FIS_SCAN_DLY_RST; // see [RL13]
            s_ff.sclk_sel <= FIS_SCLK_SEL_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign axi_rsp.awready = !s_ff.aw_got;
    assign axi_rsp.wready = !s_ff.w_got;
    assign axi_rsp.bvalid = s_ff.bvalid;
    assign axi_rsp.bresp = s_ff.bresp;
    assign axi_rsp.arready = !s_ff.rvalid;
    assign axi_rsp.rvalid = s_ff.rvalid;
    assign axi_rsp.rdata = s_ff.rdata;
    assign axi_rsp.rresp = s_ff.rresp;
    assign card_req_valid = s_ff.req_valid;
    assign card_req = s_ff.req;
    assign scan_length_delay = s_ff.scan_dly;

    fis_slow_clock u_slow_clock (
        .clk_sys(clk_sys),
        .rst(rst),
        .freq_sel(s_ff.sclk_sel),
        .slow_clk(slow_clk) // see [RL14]
    );

endmodule : fis_sequencer

// ==== sim/fis_card_model.sv ====
// card bus engine model: answers each card request with a one-cycle done pulse
// assumes the sequencer holds a request until done; lat sets the answer delay in cycles
`timescale 1ns/100ps
module fis_card_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // card request side
    input wire logic card_req_valid,
    input wire fis_pkg::fis_card_req_t card_req,
    output logic card_done,
    // answer delay
    input wire logic [3:0] lat
);
    import fis_pkg::*;
    fis_card_req_t log_q [0:31];
    int n;
    logic [3:0] cnt;
    // ------------------------------------------------------------
    // answer and log
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            card_done <= 1'b0;
            cnt <= 4'h0;
            n <= 0;
        end else if (card_done) begin
            card_done <= 1'b0;
        end else if (card_req_valid) begin
            if (cnt == lat) begin
                card_done <= 1'b1;
                log_q[n[4:0]] <= card_req;
                n <= n + 1;
                cnt <= 4'h0;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : fis_card_model

// ==== sim/fis_sequencer_chk.sv ====
// port checker of the sequencer: bus answers, card requests, slow clock
// assumes one clock domain; bound to every sequencer instance
`timescale 1ns/100ps
module fis_sequencer_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register bus
    input wire fis_pkg::fis_axi_req_t axi_req,
    input wire fis_pkg::fis_axi_rsp_t axi_rsp,
    // card side
    input wire logic card_req_valid,
    input wire fis_pkg::fis_card_req_t card_req,
    input wire logic card_done,
    input wire logic [12:0] scan_length_delay,
    input wire logic slow_clk
);
    import fis_pkg::*;
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_bresp_stands: assert property (axi_rsp.bvalid && !axi_req.bready |=>
        axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer dropped early");
    a_rdata_stands: assert property (axi_rsp.rvalid && !axi_req.rready |=>
        axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read answer dropped early");
    a_write_answers: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
        && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid) else $error("write not answered");
    a_read_answers: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read not answered");
    a_delay_by_write: assert property ($changed(scan_length_delay) |-> $rose(axi_rsp.bvalid))
        else $error("scan delay changed without a write");
    a_req_stands: assert property (card_req_valid && !card_done |=>
        card_req_valid && $stable(card_req)) else $error("card request dropped");
    a_req_kind_legal: assert property (card_req_valid |-> card_req.kind != FIS_TYPE_INT &&
        (card_req.kind == FIS_TYPE_WRITE || card_req.data == 20'h0)) else $error("bad card request");
    a_one_at_time: assert property (card_req_valid && card_done |=> !card_req_valid)
        else $error("card request not released");
    a_sclk_half: assert property ($changed(slow_clk) |=> $stable(slow_clk))
        else $error("slow clock half period too short");
    c_write_done: cover property (axi_rsp.bvalid && axi_req.bready);
    c_card_done: cover property (card_req_valid && card_done);
    c_sclk_rise: cover property ($rose(slow_clk));
endmodule : fis_sequencer_chk

bind fis_sequencer fis_sequencer_chk u_chk (.clk_sys(clk_sys), .rst(rst), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .card_req_valid(card_req_valid), .card_req(card_req), .card_done(card_done),
    .scan_length_delay(scan_length_delay), .slow_clk(slow_clk));

// ==== sim/fis_sequencer_bench.sv ====
// self-checking bench of the front-end instruction sequencer
// assumes the card model of fis_card_model.sv and the bound port checker
`timescale 1ns/100ps
module fis_sequencer_bench;
    import fis_pkg::*;
    logic clk_sys;
    logic rst;
    fis_axi_req_t axi_req;
    fis_axi_rsp_t axi_rsp;
    logic card_req_valid;
    fis_card_req_t card_req;
    logic card_done;
    logic [12:0] scan_length_delay;
    logic slow_clk;
    logic [3:0] lat;
    int num_errors;
    int compares;
    int cycles;
    logic [31:0] rdat;
    logic [1:0] resp;
    fis_card_req_t exp_q [$];
    // read, command, write pair, wait 5, loop twice back to 1, unknown op, sequence end
    logic [21:0] prog [8] = '{22'h000123, 22'h100456, 22'h200789, 22'h0abcde,
        22'h320005, 22'h312001, 22'h350000, 22'h38ffff};

    fis_sequencer u_dut (.clk_sys(clk_sys), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .card_req_valid(card_req_valid), .card_req(card_req), .card_done(card_done),
        .scan_length_delay(scan_length_delay), .slow_clk(slow_clk));
    fis_card_model u_card (.clk_sys(clk_sys), .rst(rst), .card_req_valid(card_req_valid),
        .card_req(card_req), .card_done(card_done), .lat(lat));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // a hang of the bus or the sequencer ends here
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors = num_errors + 1;
            $display("BAD %0t run hung", $time);
            conclude();
        end
    end

    // ------------------------------------------------------------
    // register bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        @(posedge clk_sys);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= {14'h0, idx, 2'b00};
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1);
        axi_req.bready <= 1'b0;
        resp = axi_rsp.bresp;
    endtask : wr

    task automatic rd(input logic [15:0] idx);
        @(posedge clk_sys);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= {14'h0, idx, 2'b00};
        axi_req.rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1);
        axi_req.rready <= 1'b0;
        rdat = axi_rsp.rdata;
        resp = axi_rsp.rresp;
    endtask : rd

    task automatic rw(input logic [15:0] idx, input logic [31:0] d, input logic [31:0] e, input logic [1:0] r);
        wr(idx, d);
        chk(resp, r);
        rd(idx);
        chk(rdat, e);
        chk(resp, r);
    endtask : rw

    task automatic sclk(input logic [1:0] s, input int per);
        realtime t0;
        wr(FIS_IDX_SCLK_SEL, {30'h0, s});
        repeat (2) @(posedge slow_clk);
        t0 = $realtime;
        @(posedge slow_clk);
        chk(int'(($realtime - t0) / 50.0), per);
    endtask : sclk

    // start, wait for done, then compare status and the logged card requests
    task automatic run(input logic [3:0] l, input logic [2:0] st);
        int base;
        base = u_card.n;
        lat <= l;
        wr(FIS_IDX_CTRL, 32'h1);
        for (int k = 0; k < 100; k++) begin
            rd(FIS_IDX_STATUS);
            if (rdat[1] === 1'b1) break;
        end
        chk(rdat[2:0], st);
        chk(u_card.n - base, exp_q.size());
        foreach (exp_q[i]) chk(u_card.log_q[base + i], exp_q[i]);
    endtask : run

    initial begin
        rst = 1'b1;
        axi_req = '0;
        lat = 4'h0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd(FIS_IDX_SCAN_DLY);
        chk(rdat, 32'h0e10);
        chk(scan_length_delay, 13'h0e10);
        rd(FIS_IDX_SCLK_SEL);
        chk(rdat, 32'h0);
        $display("test reset values done");
        rw(FIS_IDX_SCAN_DLY, 32'hffffffff, 32'h1fff, FIS_RESP_OKAY);
        chk(scan_length_delay, 13'h1fff);
        rw(FIS_IDX_ROL_A, 32'hffffffff, 32'hfff, FIS_RESP_OKAY);
        rw(FIS_IDX_ROL_B, 32'h00000a5a, 32'ha5a, FIS_RESP_OKAY);
        rw(FIS_IDX_ROL_END, 32'h00000123, 32'h123, FIS_RESP_OKAY);
        rd(FIS_IDX_ROL_A);
        chk(rdat, 32'hfff);
        rw(FIS_IDX_HIT_A, 32'ha5a5a5a5, 32'ha5a5a5a5, FIS_RESP_OKAY);
        rw(FIS_IDX_HIT_A + 16'h0040, 32'h12345678, 32'h12345678, FIS_RESP_OKAY);
        rw(FIS_IDX_HIT_END, 32'h0badcafe, 32'h0badcafe, FIS_RESP_OKAY);
        rd(FIS_IDX_HIT_A);
        chk(rdat, 32'ha5a5a5a5);
        rw(16'h0fff, 32'hffffffff, 32'h3fffff, FIS_RESP_OKAY);
        rw(16'h4000, 32'h1, 32'h0, FIS_RESP_SLVERR);
        rw(FIS_IDX_CTRL, 32'h0, 32'h0, FIS_RESP_OKAY);
        rw(FIS_IDX_SCLK_SEL, 32'hffffffff, 32'h3, FIS_RESP_OKAY);
        $display("test register map done");
        for (int s = 0; s < 4; s++) sclk(2'(s), 4 << s);
        $display("test slow clock done");
        foreach (prog[i]) wr(16'(i), {10'h0, prog[i]});
        exp_q.push_back('{FIS_TYPE_READ, 20'h00123, 20'h0});
        repeat (3) begin
            exp_q.push_back('{FIS_TYPE_CMD, 20'h00456, 20'h0});
            exp_q.push_back('{FIS_TYPE_WRITE, 20'h00789, 20'habcde});
        end
        run(4'h0, 3'b010);
        wr(FIS_IDX_CTRL, 32'h2);
        rd(FIS_IDX_STATUS);
        chk(rdat[1:0], 2'b00);
        wr(16'h0007, 32'h003fffff);
        run(4'h3, 3'b110);
        $display("test sequence runs done");
        conclude();
    end
endmodule : fis_sequencer_bench
